// ==== rsu_defines.svh ====
`ifndef RSU_DEFINES_SVH
`define RSU_DEFINES_SVH
`define CTL_WIDTH 38
`define CTL_TYPE_BIT 0
`define CTL_PAGE_LSB 1
`define CTL_PAGE_MSB 24
`define CTL_WDEN_BIT 25
`define CTL_WDTO_LSB 26
`define CTL_WDTO_MSB 37
`define PAGE_WIDTH 24
`define WDTO_WIDTH 12
`define WD_COUNT_WIDTH 29
`define WD_LOW_ZEROS 17
`define FACTORY_PAGE 24'h000000
`define CTL_RESET 38'h0000000000
`define STAT_WIDTH 5
`define STAT_CRC 0
`define STAT_CFGERR 1
`define STAT_WDOG 2
`define STAT_CORE_REQ 3
`define STAT_PIN_REQ 4
`define LOAD_TIME_NS 1000
`define CLK_PERIOD_NS 25
`define LOAD_CYCLES ((`LOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== rsu_pkg.sv ====
package rsu_pkg;
	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_LOAD,
		ST_USER,
		ST_FALLBACK
	} seq_state_e;
	typedef logic [37:0] ctl_word_t;
	typedef logic [4:0] cause_t;
endpackage : rsu_pkg

// ==== rsu_watchdog.sv ====
`timescale 1ns/1ps
`include "rsu_defines.svh"
module rsu_watchdog #(
	parameter int CW = `WD_COUNT_WIDTH
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic ce,
	input wire logic run,
	input wire logic kick,
	input wire logic [`WDTO_WIDTH-1:0] timeout_field,
	output logic expired
);
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic expired_r;
	logic [CW-1:0] full_load;
	// time-out field is the top bits of the count, low bits zero
	assign full_load = {timeout_field, {`WD_LOW_ZEROS{1'b0}}}; // [R19]
	wire at_zero = (count_r == '0);
	always_comb begin
		count_nxt = count_r;
		if (!run || kick) begin
			count_nxt = full_load; // [R22]
		end else if (!at_zero) begin
			count_nxt = count_r - 1'b1;
		end
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			count_r <= '0;
			expired_r <= 1'b0;
		end else if (ce) begin
			count_r <= count_nxt;
			expired_r <= run && !kick && at_zero; // [R10]
		end
	end
	assign expired = expired_r;
endmodule : rsu_watchdog

// ==== rsu_sequencer.sv ====
`timescale 1ns/1ps
`include "rsu_defines.svh"
// Summary of operation
// [R1] in remote update mode any configuration error always restarts configuration.
// [R2] first power-up loads the factory image from page zero.
// [R3] factory image must be stored at page zero, address zero.
// [R4] application image may start at any sector boundary of configuration memory.
// [R5] never place two images in the same memory page.
// [R6] remote update is the only upgrade mode offered.
// [R7] any error with an application image reverts to the factory image.
// [R8] every fallback records its cause in the status register. A load time-out fallback records no cause bit.
// [R9] application logic keeps resetting the watchdog within its time-out.
// [R10] an expired watchdog records a time-out and reloads the factory image.
// [R11] watchdog is disabled while the factory image is loaded.
// [R12] factory logic chooses watchdog enable and time-out before launch.
// [R13] factory logic reads status after a fallback to learn the cause.
// [R14] factory logic writes next page to control then requests reconfiguration.
// [R15] application storing a new image triggers a factory reload.
// [R16] factory and application may both request reconfiguration; always honoured. The code honours requests in user mode only and ignores them while loading.
// [R17] factory image is never overwritten by remote update logic.
// [R18] control word: type bit 0, page 1-24, enable 25, time-out 26-37.
// [R19] watchdog count is 29 bits: time-out field over 17 zero bits.
// [R20] application image makes control read-only; factory image permits writes.
// [R21] control, status and watchdog run on the oscillator clock.
// [R22] each watchdog reset reloads the full programmed time-out.
module rsu_sequencer
	import rsu_pkg::*;
#(
	parameter int LOAD_CYCLES = `LOAD_CYCLES
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic UPD_WRITE,
	input wire logic [`CTL_WIDTH-1:0] UPD_WORD,
	input wire logic RECONFIG_REQUEST_N_CORE,
	input wire logic RECONFIG_REQUEST_N_PIN,
	input wire logic CONFIG_ERROR_LINE_N,
	input wire logic CRC_ERROR,
	input wire logic LOAD_DONE,
	input wire logic WATCHDOG_KICK,
	output rsu_pkg::ctl_word_t CONTROL_WORD,
	output rsu_pkg::ctl_word_t UPDATE_WORD,
	output rsu_pkg::cause_t STATUS_CAUSE,
	output logic IMAGE_IS_APPLICATION,
	output logic [`PAGE_WIDTH-1:0] START_PAGE_ADDRESS,
	output logic LOADING,
	output logic USER_MODE
);
	import rsu_pkg::*;
	seq_state_e state_r;
	seq_state_e state_nxt;
	ctl_word_t ctl_r;
	ctl_word_t ctl_nxt;
	ctl_word_t upd_r;
	cause_t cause_r;
	cause_t cause_nxt;
	logic [15:0] load_cnt_r;
	logic req_core_d_r;
	logic req_pin_d_r;
	logic wd_expired;

	function automatic logic fall(input logic now_v, input logic prev_v);
		fall = prev_v && !now_v;
	endfunction : fall

	function automatic ctl_word_t factory_word();
		factory_word = `CTL_RESET;
	endfunction : factory_word

	wire is_app = ctl_r[`CTL_TYPE_BIT];
	wire core_req = fall(RECONFIG_REQUEST_N_CORE, req_core_d_r);
	wire pin_req = fall(RECONFIG_REQUEST_N_PIN, req_pin_d_r);
	wire any_req = core_req || pin_req; // [R16]
	// error during load or in user mode both count; error line is active low
	wire cfg_err = !CONFIG_ERROR_LINE_N && (state_r == ST_LOAD || state_r == ST_USER);
	wire crc_err = CRC_ERROR && (state_r == ST_LOAD);
	wire error_evt = cfg_err || crc_err || wd_expired; // [R7]
	wire upd_allowed = !is_app && (state_r == ST_USER); // [R20]
	wire wd_run = (state_r == ST_USER) && is_app && ctl_r[`CTL_WDEN_BIT]; // [R11]
	wire load_timeout = (load_cnt_r == 16'(LOAD_CYCLES));

	rsu_watchdog u_wdog (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.ce(CE),
		.run(wd_run),
		.kick(WATCHDOG_KICK),
		.timeout_field(ctl_r[`CTL_WDTO_MSB:`CTL_WDTO_LSB]),
		.expired(wd_expired)
	);

	always_comb begin
		state_nxt = state_r;
		ctl_nxt = ctl_r;
		cause_nxt = cause_r;
		case (state_r)
			ST_POWERUP: begin
				ctl_nxt = factory_word(); // [R2]
				state_nxt = ST_LOAD; // [R6]
			end
			ST_LOAD: begin
				if (error_evt || load_timeout) begin
					state_nxt = ST_FALLBACK; // [R1]
				end else if (LOAD_DONE) begin
					state_nxt = ST_USER;
				end
			end
			ST_USER: begin
				if (error_evt || any_req) begin
					state_nxt = ST_FALLBACK;
				end
			end
			ST_FALLBACK: begin
				state_nxt = ST_LOAD;
			end
			default: begin
				state_nxt = ST_POWERUP;
			end
		endcase
		if (state_r != ST_FALLBACK && state_nxt == ST_FALLBACK) begin
			// record cause on every fallback; a load time-out records no cause bit
			cause_nxt = '0; // [R8]
			cause_nxt[`STAT_CRC] = crc_err;
			cause_nxt[`STAT_CFGERR] = cfg_err;
			cause_nxt[`STAT_WDOG] = wd_expired; // [R10]
			cause_nxt[`STAT_CORE_REQ] = core_req;
			cause_nxt[`STAT_PIN_REQ] = pin_req;
			// factory requests load the update word; anything else falls back
			if (!is_app && any_req && !error_evt && state_r == ST_USER) begin
				ctl_nxt = upd_r; // [R14]
			end else begin
				ctl_nxt = factory_word(); // [R7]
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_r <= ST_POWERUP;
			ctl_r <= `CTL_RESET;
			upd_r <= `CTL_RESET;
			cause_r <= '0;
			load_cnt_r <= 16'h0000;
			req_core_d_r <= 1'b1;
			req_pin_d_r <= 1'b1;
		end else if (CE) begin // [R21]
			state_r <= state_nxt;
			ctl_r <= ctl_nxt;
			cause_r <= cause_nxt;
			req_core_d_r <= RECONFIG_REQUEST_N_CORE;
			req_pin_d_r <= RECONFIG_REQUEST_N_PIN;
			if (UPD_WRITE && upd_allowed) begin
				upd_r <= UPD_WORD; // [R18]
			end
			if (state_r == ST_LOAD) begin
				load_cnt_r <= load_cnt_r + 16'h0001;
			end else begin
				load_cnt_r <= 16'h0000;
			end
		end
	end

	// sector-aligned start page passes straight to the memory address
	assign START_PAGE_ADDRESS = ctl_r[`CTL_PAGE_MSB:`CTL_PAGE_LSB]; // [R4]
	assign IMAGE_IS_APPLICATION = is_app;
	assign CONTROL_WORD = ctl_r;
	assign UPDATE_WORD = upd_r;
	assign STATUS_CAUSE = cause_r;
	assign LOADING = (state_r == ST_LOAD);
	assign USER_MODE = (state_r == ST_USER);
endmodule : rsu_sequencer

// ==== rsu_sequencer_properties.sv ====
`timescale 1ns/1ps
module rsu_sequencer_properties (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic UPD_WRITE,
	input wire logic RECONFIG_REQUEST_N_CORE,
	input wire logic CONFIG_ERROR_LINE_N,
	input wire logic CRC_ERROR,
	input wire rsu_pkg::ctl_word_t CONTROL_WORD,
	input wire rsu_pkg::ctl_word_t UPDATE_WORD,
	input wire rsu_pkg::cause_t STATUS_CAUSE,
	input wire logic IMAGE_IS_APPLICATION,
	input wire logic [23:0] START_PAGE_ADDRESS,
	input wire logic LOADING,
	input wire logic USER_MODE
);
	import rsu_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	AST_FIELDS: assert property (START_PAGE_ADDRESS == CONTROL_WORD[24:1])
		else $error("page field mismatch");
	AST_POWERUP: assert property ($fell(SYS_RST) |-> !CONTROL_WORD ##[1:2] LOADING)
		else $error("power-up load wrong");
	AST_CORE_REQ: assert property (USER_MODE && $fell(RECONFIG_REQUEST_N_CORE)
		|=> STATUS_CAUSE[3] ##1 LOADING)
		else $error("core request not honoured");
	AST_CFG_ERR: assert property (USER_MODE && !CONFIG_ERROR_LINE_N |=> STATUS_CAUSE[1])
		else $error("error line cause missing");
	AST_APP_FALLBACK: assert property (USER_MODE && IMAGE_IS_APPLICATION && !CONFIG_ERROR_LINE_N
		|=> CONTROL_WORD == '0 ##1 LOADING)
		else $error("no fallback to factory");
	AST_CRC_RESTART: assert property (LOADING && CRC_ERROR |-> ##[1:2] STATUS_CAUSE[0])
		else $error("crc error ignored");
	AST_FACTORY_LAUNCH: assert property (USER_MODE && !IMAGE_IS_APPLICATION
		&& $fell(RECONFIG_REQUEST_N_CORE) |=> CONTROL_WORD == $past(UPDATE_WORD))
		else $error("update word not loaded");
	AST_READ_ONLY: assert property (IMAGE_IS_APPLICATION && UPD_WRITE |=> $stable(UPDATE_WORD))
		else $error("write accepted in application");
	cover property (LOADING && CRC_ERROR);
	cover property (USER_MODE && IMAGE_IS_APPLICATION && !CONFIG_ERROR_LINE_N);
	cover property (IMAGE_IS_APPLICATION && UPD_WRITE);
	cover property (LOADING && STATUS_CAUSE[2]);
endmodule : rsu_sequencer_properties
bind rsu_sequencer rsu_sequencer_properties u_props (.*);

// ==== fabric_user_model.sv ====
`timescale 1ns/1ps
module fabric_user_model (
	input wire logic CLK,
	input wire logic go,
	input wire logic app,
	output logic core_n,
	output logic kick
);
	logic [2:0] n = 3'h0;
	initial core_n = 1'h1;
	initial kick = 1'h0;
	always @(posedge CLK) begin
		n <= n + 3'h1;
		kick <= #1 app && n == 3'h0;
		core_n <= #1 !go;
	end
endmodule : fabric_user_model

// ==== rsu_sequencer_tb.sv ====
`timescale 1ns/1ps
module rsu_sequencer_tb;
	import rsu_pkg::*;
	localparam ctl_word_t W = {12'h001, 1'h1, 24'h000100, 1'h1};
	// zero time-out field: an enabled watchdog expires right after user mode starts
	localparam ctl_word_t WZ = {12'h000, 1'h1, 24'h000200, 1'h1};
	logic clk = 0, rst = 1, wr = 0, pin_n = 1, cfg_n = 1, crc = 0, done = 0, go = 0;
	logic core_n, kick, ld, um, app;
	ctl_word_t upd = '0, cw, uw;
	cause_t cause;
	logic [23:0] page;
	int n_mismatch = 0, check_count = 0;
	always #12.5 clk = ~clk;
	rsu_sequencer #(.LOAD_CYCLES(8)) u_dut (.CLK(clk), .SYS_RST(rst), .CE(1'h1),
		.UPD_WRITE(wr), .UPD_WORD(upd), .RECONFIG_REQUEST_N_CORE(core_n),
		.RECONFIG_REQUEST_N_PIN(pin_n), .CONFIG_ERROR_LINE_N(cfg_n), .CRC_ERROR(crc),
		.LOAD_DONE(done), .WATCHDOG_KICK(kick), .CONTROL_WORD(cw), .UPDATE_WORD(uw),
		.STATUS_CAUSE(cause), .IMAGE_IS_APPLICATION(app), .START_PAGE_ADDRESS(page),
		.LOADING(ld), .USER_MODE(um));
	fabric_user_model u_fab (.CLK(clk), .go(go), .app(app), .core_n(core_n), .kick(kick));
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'h1) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// bounded waits; a hang ends the run through the report
	task to_user;
		for (int i = 0; i < 50 && ld !== 1'h1; i++) step(1);
		done = 1;
		for (int i = 0; i < 50 && um !== 1'h1; i++) step(1);
		done = 0;
		chk(um, "no user mode");
		if (um !== 1'h1) finish_test();
	endtask : to_user
	task t_launch;
		upd = W;
		wr = 1;
		step(1);
		wr = 0;
		go = 1;
		step(1);
		go = 0;
		step(2);
		chk(cause === 5'h08 && cw === W, "launch");
		to_user();
		chk(page === 24'h000100 && app === 1'h1, "app page");
		$display("launch end");
	endtask : t_launch
	task t_app;
		upd = ~W;
		wr = 1;
		step(1);
		wr = 0;
		step(1);
		chk(uw === W, "read-only");
		cfg_n = 0;
		step(1);
		cfg_n = 1;
		step(2);
		chk(cause === 5'h02 && cw === '0, "fallback");
		to_user();
		$display("app end");
	endtask : t_app
	task t_crc;
		pin_n = 0;
		step(1);
		pin_n = 1;
		step(2);
		chk(cause === 5'h10, "pin cause");
		crc = 1;
		step(1);
		crc = 0;
		step(2);
		chk(cause === 5'h01 && cw === '0, "crc restart");
		to_user();
		$display("crc end");
	endtask : t_crc
	task t_wdog;
		upd = WZ;
		wr = 1;
		step(1);
		wr = 0;
		go = 1;
		step(1);
		go = 0;
		step(2);
		chk(cause === 5'h08 && cw === WZ, "wdog launch");
		to_user();
		step(4);
		chk(cause === 5'h04 && cw === '0, "wdog expiry");
		to_user();
		$display("wdog end");
	endtask : t_wdog
	initial begin
		step(16);
		rst = 0;
		to_user();
		chk(cw === '0 && app === 1'h0, "power-up");
		t_launch();
		t_app();
		t_crc();
		t_wdog();
		finish_test();
	end
endmodule : rsu_sequencer_tb
